// [sgw_cfg.svh]
// Offsets, field positions, reset values and timing of the control registers
`ifndef SGW_CFG_SVH
`define SGW_CFG_SVH

`define SGW_ADDR_GP_CTRL        8'h13
`define SGW_ADDR_SELF_TEST      8'h14
`define SGW_ADDR_WDOG_CTRL      8'h16

`define SGW_GP_RESET            8'h10
`define SGW_SELF_TEST_RESET     8'h00
`define SGW_WDOG_RESET          8'hfe

`define SGW_GP_MAP_STRAP_BIT    7
`define SGW_GP_MAP_OVR_BIT      6
`define SGW_GP_MAP_VAL_BIT      5
`define SGW_GP_RSVD_BIT         4
`define SGW_GP_LOW_FREQ_BIT     3
`define SGW_GP_REPEATER_BIT     2
`define SGW_GP_LEGACY_BIT       1
`define SGW_GP_AUDIO_B_BIT      0

`define SGW_ST_SRC_HI           2
`define SGW_ST_SRC_LO           1
`define SGW_ST_ACTIVE_BIT       0
`define SGW_SRC_EXT_CLK         2'h0
`define SGW_SRC_OSC             2'h1

`define SGW_WDOG_TIME_HI        7
`define SGW_WDOG_TIME_LO        1
`define SGW_WDOG_DIS_BIT        0

`define SGW_CLK_PERIOD_NS       4
`define SGW_WDOG_STEP_NS        2000000

`endif

// [sgw_pkg.sv]
// Types shared by the control register bank and its watchdog
package sgw_pkg;

    typedef struct packed {
        logic lane_map;
        logic low_freq;
        logic repeater;
        logic legacy;
        logic audio_b;
    } sgw_strap_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sgw_reg_req_type;

    typedef enum logic [1:0] {
        WDOG_IDLE = 2'b01,
        WDOG_RUN  = 2'b10
    } sgw_wdog_state_type;

endpackage

// [sgw_watchdog.sv]
// Control-channel transaction watchdog
`timescale 1ns/1ps
`include "sgw_cfg.svh"

module sgw_watchdog #(
    parameter int STEP_CYCLES = `SGW_WDOG_STEP_NS / `SGW_CLK_PERIOD_NS
) (
    input  wire logic       clk_sys,     // System clock
    input  wire logic       reset,       // Synchronous reset
    input  wire logic       txn_start,   // Transaction begins
    input  wire logic       txn_done,    // Transaction completed
    input  wire logic       enable,      // Watchdog allowed to run
    input  wire logic [6:0] timeout,     // Timeout in 2 ms steps
    output logic            txn_abort    // Abort pulse
);

    localparam int CW = (STEP_CYCLES > 2) ? $clog2(STEP_CYCLES) : 1;

    sgw_pkg::sgw_wdog_state_type state_r;
    logic [CW-1:0]               cycle_r;
    logic [6:0]                  unit_r;
    logic [6:0]                  limit_r;  // Taken at start; rewrites can't skip it
    logic                        step_end;
    logic                        expire;

    assign step_end = (cycle_r == CW'(STEP_CYCLES - 1));
    assign expire   = step_end && ((unit_r + 7'h01) == limit_r);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r   <= sgw_pkg::WDOG_IDLE;
            cycle_r   <= '0;
            unit_r    <= 7'h00;
            limit_r   <= 7'h00;
            txn_abort <= 1'b0;
        end else begin
            txn_abort <= 1'b0;
            if (txn_start) begin
                state_r <= sgw_pkg::WDOG_RUN;         // see R15
                cycle_r <= '0;
                unit_r  <= 7'h00;
                limit_r <= timeout;                   // see R12
            end else begin
                unique case (state_r)
                    sgw_pkg::WDOG_IDLE: begin
                        cycle_r <= '0;
                        unit_r  <= 7'h00;
                    end
                    sgw_pkg::WDOG_RUN: begin
                        if (txn_done || !enable) begin
                            state_r <= sgw_pkg::WDOG_IDLE; // see R14, R15
                            cycle_r <= '0;
                            unit_r  <= 7'h00;
                        end else if (expire) begin
                            state_r   <= sgw_pkg::WDOG_IDLE;
                            txn_abort <= 1'b1;        // see R11
                            cycle_r   <= '0;
                            unit_r    <= 7'h00;
                        end else if (step_end) begin
                            cycle_r <= '0;
                            unit_r  <= unit_r + 7'h01; // see R12
                        end else begin
                            cycle_r <= cycle_r + CW'(1);
                        end
                    end
                endcase
            end
        end
    end

    a_abort_while_running: assert property (@(posedge clk_sys) disable iff (reset)
        txn_abort |-> $past(state_r == sgw_pkg::WDOG_RUN) && $past(enable)
            && !$past(txn_done) && !$past(txn_start)) // see R11
        else $error("watchdog aborted outside a running transaction");

    a_start_restarts: assert property (@(posedge clk_sys) disable iff (reset)
        txn_start |=> state_r == sgw_pkg::WDOG_RUN && unit_r == 7'h00
            && cycle_r == '0 && !txn_abort) // see R15
        else $error("watchdog did not restart on transaction start");

    a_disable_stops: assert property (@(posedge clk_sys) disable iff (reset)
        (state_r == sgw_pkg::WDOG_RUN && !enable && !txn_start)
            |=> state_r == sgw_pkg::WDOG_IDLE && !txn_abort) // see R14
        else $error("disabled watchdog kept running");

    a_done_clears: assert property (@(posedge clk_sys) disable iff (reset)
        (txn_done && !txn_start) |=> state_r == sgw_pkg::WDOG_IDLE
            && unit_r == 7'h00 && !txn_abort) // see R15
        else $error("completed transaction left watchdog counting");

    a_unit_bounded: assert property (@(posedge clk_sys) disable iff (reset)
        (state_r == sgw_pkg::WDOG_RUN && limit_r != 7'h00)
            |-> unit_r < limit_r) // see R12
        else $error("watchdog count passed the programmed timeout");

    c_abort_seen: cover property (@(posedge clk_sys) disable iff (reset)
        txn_abort);

endmodule

// [sgw_ctrl_regs.sv]
// General-purpose, self-test and watchdog control registers
`timescale 1ns/1ps
`include "sgw_cfg.svh"

// What this block does
// R1: Bit 7 returns lane map strap level
// R2: Bit 6 picks strap or bit 5
// R3: Override value 0 LSBs, 1 MSBs lane three
// R4: Bit 3 returns low frequency strap
// R5: Bit 2 returns repeater strap
// R6: Bit 1 returns legacy compatibility mode
// R7: Bit 0 returns second audio channel mode
// R8: Functional mode falls back to oscillator
// R9: Self-test source: 00 external, 01 oscillator
// R10: Low frequency strap slows oscillator
// R11: Watchdog aborts stalled control channel transaction
// R12: Timeout field counts 2 ms steps, reset fe
// R13: Host never writes zero timeout
// R14: Bit 0 set stops the watchdog
// R15: Counter restarts per transaction, clears at end
module sgw_ctrl_regs #(
    parameter int WDOG_STEP_CYCLES = `SGW_WDOG_STEP_NS / `SGW_CLK_PERIOD_NS
) (
    input  wire logic                    clk_sys,        // System clock
    input  wire logic                    reset,          // Synchronous reset
    input  wire sgw_pkg::sgw_reg_req_type reg_req,       // Register access
    output logic [7:0]                   reg_rdata,      // Read data
    output logic                         reg_rvalid,     // Read data valid
    input  wire sgw_pkg::sgw_strap_type  straps,         // Strap levels
    input  wire logic                    self_test,      // Self-test running
    input  wire logic                    pclk_present,   // Pixel clock seen
    input  wire logic                    osc_fallback_en, // Fallback allowed
    input  wire logic                    txn_start,      // Channel txn start
    input  wire logic                    txn_done,       // Channel txn done
    output logic                         lane_map_select, // 1: MSBs lane 3
    output logic                         use_internal_osc, // Clock from osc
    output logic                         osc_freq_low,   // Osc at low rate
    output logic                         txn_abort       // Txn terminated
);

    logic [1:0] map_ctrl_r;   // [1] override, [0] value
    logic [1:0] osc_src_r;
    logic [7:0] wdog_r;
    logic       wr_gp;
    logic       wr_st;
    logic       wr_wd;

    assign wr_gp = reg_req.wr && (reg_req.addr == `SGW_ADDR_GP_CTRL);
    assign wr_st = reg_req.wr && (reg_req.addr == `SGW_ADDR_SELF_TEST);
    assign wr_wd = reg_req.wr && (reg_req.addr == `SGW_ADDR_WDOG_CTRL);

    function automatic logic [7:0] read_value(
        input logic [7:0]            addr,
        input sgw_pkg::sgw_strap_type s,
        input logic [1:0]            map_ctrl,
        input logic [1:0]            src,
        input logic                  st,
        input logic [7:0]            wd
    );
        logic [7:0] v;
        v = 8'h00;
        unique case (addr)
            `SGW_ADDR_GP_CTRL: begin
                v = `SGW_GP_RESET;
                v[`SGW_GP_MAP_STRAP_BIT] = s.lane_map;   // see R1
                v[`SGW_GP_MAP_OVR_BIT]   = map_ctrl[1];
                v[`SGW_GP_MAP_VAL_BIT]   = map_ctrl[0];
                v[`SGW_GP_LOW_FREQ_BIT]  = s.low_freq;   // see R4
                v[`SGW_GP_REPEATER_BIT]  = s.repeater;   // see R5
                v[`SGW_GP_LEGACY_BIT]    = s.legacy;     // see R6
                v[`SGW_GP_AUDIO_B_BIT]   = s.audio_b;    // see R7
            end
            `SGW_ADDR_SELF_TEST: begin
                v[`SGW_ST_SRC_HI:`SGW_ST_SRC_LO] = src;
                v[`SGW_ST_ACTIVE_BIT]            = st;
            end
            `SGW_ADDR_WDOG_CTRL: begin
                v = wd;
            end
            default: begin
                v = 8'h00;
            end
        endcase
        return v;
    endfunction

    // Lane map override register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            map_ctrl_r <= 2'h0;
        end else if (wr_gp) begin
            map_ctrl_r <= {reg_req.wdata[`SGW_GP_MAP_OVR_BIT],
                           reg_req.wdata[`SGW_GP_MAP_VAL_BIT]};
        end
    end

    // Oscillator source field
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            osc_src_r <= `SGW_SRC_EXT_CLK;
        end else if (wr_st) begin
            osc_src_r <= reg_req.wdata[`SGW_ST_SRC_HI:`SGW_ST_SRC_LO];
        end
    end

    // Watchdog control register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wdog_r <= `SGW_WDOG_RESET;                   // see R12
        end else if (wr_wd) begin
            wdog_r <= reg_req.wdata;
        end
    end

    // Read port, one cycle latency
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.rd;
            if (reg_req.rd) begin
                reg_rdata <= read_value(reg_req.addr, straps, map_ctrl_r,
                                        osc_src_r, self_test, wdog_r);
            end
        end
    end

    // Lane map selection
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lane_map_select <= 1'b0;
        end else begin
            lane_map_select <= map_ctrl_r[1] ? map_ctrl_r[0]  // see R2, R3
                                             : straps.lane_map;
        end
    end

    // Clock source selection
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            use_internal_osc <= 1'b0;
            osc_freq_low     <= 1'b0;
        end else begin
            if (self_test) begin
                use_internal_osc <= (osc_src_r == `SGW_SRC_OSC); // see R9
            end else begin
                use_internal_osc <= !pclk_present && osc_fallback_en; // see R8
            end
            osc_freq_low <= straps.low_freq;             // see R10
        end
    end

    sgw_watchdog #(
        .STEP_CYCLES (WDOG_STEP_CYCLES)
    ) u_watchdog (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .txn_start (txn_start),
        .txn_done  (txn_done),
        .enable    (!wdog_r[`SGW_WDOG_DIS_BIT]),          // see R14
        .timeout   (wdog_r[`SGW_WDOG_TIME_HI:`SGW_WDOG_TIME_LO]), // see R12
        .txn_abort (txn_abort)                           // see R11
    );

    a_strap_readback: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_req.rd && reg_req.addr == `SGW_ADDR_GP_CTRL)
            |=> reg_rvalid
            && reg_rdata[`SGW_GP_MAP_STRAP_BIT] == $past(straps.lane_map)
            && reg_rdata[`SGW_GP_LOW_FREQ_BIT] == $past(straps.low_freq)
            && reg_rdata[`SGW_GP_REPEATER_BIT] == $past(straps.repeater))
        else $error("strap bits read back wrong"); // see R1

    a_status_readback: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_req.rd && reg_req.addr == `SGW_ADDR_GP_CTRL)
            |=> reg_rdata[`SGW_GP_LEGACY_BIT] == $past(straps.legacy)
            && reg_rdata[`SGW_GP_AUDIO_B_BIT] == $past(straps.audio_b)
            && reg_rdata[`SGW_GP_RSVD_BIT])
        else $error("mode status bits read back wrong"); // see R6

    a_map_override: assert property (@(posedge clk_sys) disable iff (reset)
        (wr_gp && reg_req.wdata[`SGW_GP_MAP_OVR_BIT])
            ##1 !wr_gp |=> lane_map_select
            == $past(reg_req.wdata[`SGW_GP_MAP_VAL_BIT], 2))
        else $error("override value not driven to lane map"); // see R3

    a_map_from_strap: assert property (@(posedge clk_sys) disable iff (reset)
        (wr_gp && !reg_req.wdata[`SGW_GP_MAP_OVR_BIT])
            ##1 !wr_gp |=> lane_map_select == $past(straps.lane_map))
        else $error("lane map did not follow strap"); // see R2

    a_test_src_osc: assert property (@(posedge clk_sys) disable iff (reset)
        (self_test && osc_src_r == `SGW_SRC_OSC) |=> use_internal_osc)
        else $error("self-test did not select oscillator"); // see R9

    a_test_src_ext: assert property (@(posedge clk_sys) disable iff (reset)
        (self_test && osc_src_r == `SGW_SRC_EXT_CLK) |=> !use_internal_osc)
        else $error("self-test did not select pixel clock"); // see R9

    a_func_fallback: assert property (@(posedge clk_sys) disable iff (reset)
        (!self_test && !pclk_present && osc_fallback_en)
            |=> use_internal_osc)
        else $error("no oscillator fallback without pixel clock"); // see R8

    a_low_freq_osc: assert property (@(posedge clk_sys) disable iff (reset)
        straps.low_freq [*2] |-> osc_freq_low)
        else $error("oscillator not slowed by low frequency strap"); // see R10

    a_wdog_default: assert property (@(posedge clk_sys)
        reset |=> wdog_r == `SGW_WDOG_RESET)
        else $error("watchdog control reset value wrong"); // see R12

    a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_req.rd && reg_req.addr != `SGW_ADDR_GP_CTRL
            && reg_req.addr != `SGW_ADDR_SELF_TEST
            && reg_req.addr != `SGW_ADDR_WDOG_CTRL)
            |=> reg_rvalid && reg_rdata == 8'h00)
        else $error("unmapped address read not zero");

    c_map_override: cover property (@(posedge clk_sys) disable iff (reset)
        wr_gp && reg_req.wdata[`SGW_GP_MAP_OVR_BIT]);

    c_self_test_osc: cover property (@(posedge clk_sys) disable iff (reset)
        self_test && use_internal_osc);

    c_wdog_disabled: cover property (@(posedge clk_sys) disable iff (reset)
        wr_wd && reg_req.wdata[`SGW_WDOG_DIS_BIT]);

endmodule

// [sgw_host_model.sv]
// Host model driving the register port of the control register bank
`timescale 1ns/1ps
`include "sgw_cfg.svh"

module sgw_host_model (
    input  wire logic             clk_sys,    // System clock
    output sgw_pkg::sgw_reg_req_type reg_req, // Register access
    input  wire logic [7:0]       reg_rdata,  // Read data
    input  wire logic             reg_rvalid  // Read data valid
);
    initial reg_req = '0;

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        // Zero timeout is never programmed
        if (addr == `SGW_ADDR_WDOG_CTRL && data[7:1] == 7'h00) begin
            return;
        end
        @(posedge clk_sys);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge clk_sys);
        reg_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] addr, output logic [7:0] data,
                      output logic valid);
        @(posedge clk_sys);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge clk_sys);
        reg_req.rd <= 1'b0;
        #1;
        data  = reg_rdata;
        valid = reg_rvalid;
    endtask
endmodule

// [sgw_ctrl_regs_bench.sv]
// Self-checking bench for the control register bank
`timescale 1ns/1ps
`include "sgw_cfg.svh"

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
    $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end

module sgw_ctrl_regs_bench;
    typedef struct packed {
        logic [4:0] strap_bits;
        logic       test;
        logic       pclk;
        logic       fb;
        logic [7:0] w13;
        logic [7:0] w14;
        logic [7:0] r13;
        logic [7:0] r14;
        logic       lane;
        logic       osc;
    } sgw_row_type;

    logic                     clk_sys = 1'b0;
    logic                     reset   = 1'b1;
    sgw_pkg::sgw_reg_req_type reg_req;
    logic [7:0]               reg_rdata;
    logic                     reg_rvalid;
    sgw_pkg::sgw_strap_type   straps = '0;
    logic                     self_test = 1'b0;
    logic                     pclk_present = 1'b1;
    logic                     osc_fallback_en = 1'b0;
    logic                     txn_start = 1'b0;
    logic                     txn_done = 1'b0;
    logic                     lane_map_select;
    logic                     use_internal_osc;
    logic                     osc_freq_low;
    logic                     txn_abort;
    int                       fails = 0;
    int                       cmp_count = 0;
    int                       cyc = 0;
    int                       n;
    logic [7:0]               d;
    logic                     v;
    sgw_row_type              rows [6] = '{
        '{5'b10000, 0, 1, 1, 8'h00, 8'h00, 8'h90, 8'h00, 1, 0},
        '{5'b01111, 0, 0, 1, 8'h60, 8'h00, 8'h7f, 8'h00, 1, 1},
        '{5'b10000, 1, 1, 1, 8'h40, 8'h02, 8'hd0, 8'h03, 0, 1},
        '{5'b00000, 1, 0, 1, 8'hff, 8'hff, 8'h70, 8'h07, 1, 0},
        '{5'b00100, 1, 0, 1, 8'h00, 8'h00, 8'h14, 8'h01, 0, 0},
        '{5'b00010, 0, 0, 0, 8'h00, 8'h02, 8'h12, 8'h02, 0, 0}
    };

    always #2 clk_sys = ~clk_sys;

    sgw_ctrl_regs #(.WDOG_STEP_CYCLES(4)) dut (
        .clk_sys          (clk_sys),
        .reset            (reset),
        .reg_req          (reg_req),
        .reg_rdata        (reg_rdata),
        .reg_rvalid       (reg_rvalid),
        .straps           (straps),
        .self_test        (self_test),
        .pclk_present     (pclk_present),
        .osc_fallback_en  (osc_fallback_en),
        .txn_start        (txn_start),
        .txn_done         (txn_done),
        .lane_map_select  (lane_map_select),
        .use_internal_osc (use_internal_osc),
        .osc_freq_low     (osc_freq_low),
        .txn_abort        (txn_abort)
    );

    sgw_host_model host (
        .clk_sys    (clk_sys),
        .reg_req    (reg_req),
        .reg_rdata  (reg_rdata),
        .reg_rvalid (reg_rvalid)
    );

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Pulse a transaction start and count edges until an abort shows
    task automatic start_and_wait(output int cnt);
        @(posedge clk_sys);
        txn_start <= 1'b1;
        @(posedge clk_sys);
        txn_start <= 1'b0;
        cnt = 0;
        while (txn_abort !== 1'b1 && cnt < 40) begin
            @(posedge clk_sys);
            cnt++;
            #1;
        end
    endtask

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            complete_run();
        end
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        #1;
        `CHK(lane_map_select, 1'b0)
        host.rd(`SGW_ADDR_GP_CTRL, d, v);
        `CHK(d, `SGW_GP_RESET)
        host.rd(`SGW_ADDR_SELF_TEST, d, v);
        `CHK(d, `SGW_SELF_TEST_RESET)
        host.rd(`SGW_ADDR_WDOG_CTRL, d, v);
        `CHK(d, `SGW_WDOG_RESET)
        host.rd(8'h15, d, v);
        `CHK({v, d}, 9'h100)

        foreach (rows[i]) begin
            @(posedge clk_sys);
            straps          <= rows[i].strap_bits;
            self_test       <= rows[i].test;
            pclk_present    <= rows[i].pclk;
            osc_fallback_en <= rows[i].fb;
            host.wr(`SGW_ADDR_GP_CTRL, rows[i].w13);
            host.wr(`SGW_ADDR_SELF_TEST, rows[i].w14);
            host.rd(`SGW_ADDR_GP_CTRL, d, v);
            `CHK({v, d}, {1'b1, rows[i].r13})
            host.rd(`SGW_ADDR_SELF_TEST, d, v);
            `CHK({v, d}, {1'b1, rows[i].r14})
            `CHK(lane_map_select, rows[i].lane)
            `CHK(use_internal_osc, rows[i].osc)
            `CHK(osc_freq_low, rows[i].strap_bits[3])
        end

        host.wr(`SGW_ADDR_WDOG_CTRL, 8'h04);
        host.rd(`SGW_ADDR_WDOG_CTRL, d, v);
        `CHK(d, 8'h04)
        start_and_wait(n);
        `CHK(n, 8)
        @(posedge clk_sys);
        #1;
        `CHK(txn_abort, 1'b0)

        @(posedge clk_sys);
        txn_start <= 1'b1;
        @(posedge clk_sys);
        txn_start <= 1'b0;
        repeat (2) @(posedge clk_sys);
        txn_done <= 1'b1;
        n = 0;
        @(posedge clk_sys);
        txn_done <= 1'b0;
        repeat (20) begin
            @(posedge clk_sys);
            #1;
            if (txn_abort === 1'b1) n++;
        end
        `CHK(n, 0)

        @(posedge clk_sys);
        txn_start <= 1'b1;
        @(posedge clk_sys);
        txn_start <= 1'b0;
        repeat (5) @(posedge clk_sys);
        start_and_wait(n);
        `CHK(n, 8)

        host.wr(`SGW_ADDR_WDOG_CTRL, 8'h05);
        start_and_wait(n);
        `CHK(n, 40)
        host.wr(`SGW_ADDR_WDOG_CTRL, 8'h06);
        start_and_wait(n);
        `CHK(n, 12)

        // Reset in mid-transaction with the lane override set
        @(posedge clk_sys);
        straps <= 5'b10000;
        host.wr(`SGW_ADDR_GP_CTRL, 8'h40);
        @(posedge clk_sys);
        #1;
        `CHK(lane_map_select, 1'b0)
        @(posedge clk_sys);
        txn_start <= 1'b1;
        @(posedge clk_sys);
        txn_start <= 1'b0;
        reset     <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        #1;
        `CHK(lane_map_select, 1'b1)
        host.rd(`SGW_ADDR_GP_CTRL, d, v);
        `CHK({v, d}, 9'h190)
        host.rd(`SGW_ADDR_WDOG_CTRL, d, v);
        `CHK(d, `SGW_WDOG_RESET)
        host.wr(`SGW_ADDR_WDOG_CTRL, 8'h04);
        n = 0;
        repeat (20) begin
            @(posedge clk_sys);
            #1;
            if (txn_abort === 1'b1) n++;
        end
        `CHK(n, 0)
        complete_run();
    end
endmodule
